// ==== shared/sps_pkg.sv ====
// ==========================================
// Shared constants and types for the stepper phase sequencer
package sps_pkg;

    // ==========================================
    // Timing
    localparam int SPS_CLK_MHZ = 50;           // Core clock rate in MHz
    localparam int SPS_RESET_MIN_US = 10;      // Least reset hold after power-up
    localparam int SPS_RESET_MIN_CYC = SPS_RESET_MIN_US * SPS_CLK_MHZ;

    // ==========================================
    // Sequence geometry
    localparam int SPS_POS_W = 3;              // Width of the step index
    localparam logic [2:0] SPS_POS_INIT = 3'h0; // Initial step index
    localparam logic [2:0] SPS_POS_ONE = 3'h1;  // Half-step increment
    localparam logic [2:0] SPS_POS_TWO = 3'h2;  // Full-step increment
    localparam logic SPS_MODE_FULL = 1'b0;     // Mode select low: two-phase
    localparam logic SPS_DIR_FWD = 1'b0;       // Direction select low: forward

    // Winding drive set, one bit per phase output
    typedef struct packed {
        logic winding_one_pos;                 // Phase A
        logic winding_one_neg;                 // Phase A return
        logic winding_two_pos;                 // Phase B
        logic winding_two_neg;                 // Phase B return
    } sps_phase_t;

    localparam sps_phase_t SPS_PHASE_OFF = 4'h0; // All switches off

    // Half-step table: even index two windings, odd index one winding
    localparam logic [3:0] SPS_TABLE [0:7] = '{
        4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1
    };

endpackage

// ==== core/sps_sequencer.sv ====
`timescale 1ns/1ns
// Functional notes
// - Advance one pattern per step clock rising edge.
// - Full-step two windings; half-step alternates one/two.
// - Sample mode select at step rising edge.
// - Mode low full-step, high half-step.
// - Direction select sets phase stepping order.
// - Direction low forward, high reverse.
// - Enable low forces all phase outputs off.
// - Enable high resumes from held position.
// - Reset low returns initial step, outputs off.
module sps_sequencer
    import sps_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic step_clock,
    input wire logic mode_select,
    input wire logic direction_select,
    input wire logic output_enable,
    output sps_phase_t phase_out,
    output logic [SPS_POS_W-1:0] step_position
);

    // ==========================================
    // Input synchronisers
    logic [3:0] sync_a;   // First stage, read only by second stage
    logic [3:0] sync_b;   // Second stage, safe for logic
    logic step_prev;      // Delayed step level for edge detection
    logic step_rise;      // One-cycle pulse on step rising edge
    logic step_go;        // Step edge accepted while driving
    logic mode_s;         // Synchronised mode select
    logic dir_s;          // Synchronised direction select
    logic en_s;           // Synchronised output enable
    logic [SPS_POS_W-1:0] pos;      // Current step index
    logic [SPS_POS_W-1:0] next_pos; // Index after the next step
    logic [SPS_POS_W-1:0] inc;      // Step size for the sampled mode
    sps_phase_t next_phase;         // Drive pattern for next cycle

    // Two flops on the step, mode, direction and enable pin inputs
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else if (clk_en) begin
            sync_a <= {step_clock, mode_select, direction_select,
                       output_enable};
            sync_b <= sync_a;
        end
    end

    assign step_rise = sync_b[3] & ~step_prev;
    assign mode_s = sync_b[2];
    assign dir_s = sync_b[1];
    assign en_s = sync_b[0];
    // Steps only count while the drive is on, so the position holds
    assign step_go = step_rise & en_s;

    // Edge detector history
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            step_prev <= 1'b0;
        end else if (clk_en) begin
            step_prev <= sync_b[3];
        end
    end

    // ==========================================
    // Position arithmetic
    always_comb begin
        // Mode is taken at the edge itself
        inc = (mode_s == SPS_MODE_FULL) ? SPS_POS_TWO : SPS_POS_ONE;
        // Odd index in full step moves one to rejoin the even set
        if (mode_s == SPS_MODE_FULL && pos[0]) begin
            inc = SPS_POS_ONE;
        end
        if (dir_s == SPS_DIR_FWD) begin
            next_pos = pos + inc;
        end else begin
            next_pos = pos - inc;
        end
        // Full step lands on even indices only: two windings on
        if (mode_s == SPS_MODE_FULL) begin
            next_pos[0] = 1'b0;
        end
    end

    // Step index advances once per step rising edge, wraps mod 8
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pos <= SPS_POS_INIT;
        end else if (clk_en && step_go) begin
            // Held while the drive is off, resumes from here
            pos <= next_pos;
        end
    end

    // ==========================================
    // Output stage
    always_comb begin
        if (en_s) begin
            next_phase = SPS_TABLE[pos];
        end else begin
            next_phase = SPS_PHASE_OFF;
        end
    end

    // Registered winding drive
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            phase_out <= SPS_PHASE_OFF;
            step_position <= SPS_POS_INIT;
        end else if (clk_en) begin
            phase_out <= next_phase;
            step_position <= pos;
        end
    end

    // ==========================================
    // Checks

    // Enabled clock cycle with the drive pin low
    sequence disabled_s;
        clk_en && !en_s;
    endsequence

    // Accepted step, full-step forward
    sequence full_fwd_s;
        clk_en && step_go && !mode_s && !dir_s;
    endsequence

    // Accepted step, full-step reverse
    sequence full_rev_s;
        clk_en && step_go && !mode_s && dir_s;
    endsequence

    // Accepted step, half-step forward
    sequence half_fwd_s;
        clk_en && step_go && mode_s && !dir_s;
    endsequence

    // Accepted step, half-step reverse
    sequence half_rev_s;
        clk_en && step_go && mode_s && dir_s;
    endsequence

    // Drive pin low turns every switch off next cycle
    outputs_off_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        disabled_s |=> phase_out == SPS_PHASE_OFF)
        else $error("outputs not off while disabled");

    // Position frozen while the drive is off
    hold_pos_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        disabled_s |=> pos == $past(pos))
        else $error("position moved while disabled");

    // Enabled drive shows the held position
    resume_pos_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        clk_en && en_s |=> phase_out == SPS_TABLE[$past(pos)])
        else $error("enabled output not from held position");

    // Reset clears the index and the drive
    reset_init_a: assert property (
        @(posedge core_clk)
        !resetn |=> pos == SPS_POS_INIT && phase_out == SPS_PHASE_OFF)
        else $error("reset did not clear sequencer");

    // Reset clears the reported index
    reset_report_a: assert property (
        @(posedge core_clk)
        !resetn |=> step_position == SPS_POS_INIT)
        else $error("reset did not clear reported index");

    // No step edge, no movement
    step_once_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        clk_en && !step_rise |=> pos == $past(pos))
        else $error("position moved without step edge");

    // Edge pulse lasts one enabled cycle
    edge_pulse_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        clk_en && step_rise |=> !step_rise)
        else $error("step edge pulse held too long");

    // Clock enable low freezes the whole sequencer
    freeze_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !clk_en |=> pos == $past(pos) && phase_out == $past(phase_out))
        else $error("state moved while clock enable low");

    // Reported index trails the live one by a cycle
    report_pos_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        clk_en |=> step_position == $past(pos))
        else $error("reported index not the live one");

    // Full step forward lands ahead on an even index
    full_two_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        full_fwd_s |=> pos == (($past(pos) + SPS_POS_TWO) & 3'h6))
        else $error("full step forward wrong");

    // Full step reverse lands behind on an even index
    full_rev_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        full_rev_s |=> pos == (($past(pos) - SPS_POS_ONE) & 3'h6))
        else $error("full step reverse wrong");

    // Half step forward moves one ahead
    half_fwd_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        half_fwd_s |=> pos == $past(pos) + SPS_POS_ONE)
        else $error("half step forward wrong");

    // Half step reverse moves one behind
    half_rev_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        half_rev_s |=> pos == $past(pos) - SPS_POS_ONE)
        else $error("half step reverse wrong");

    // Full step always leaves two windings on
    full_even_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (full_fwd_s or full_rev_s) |=> pos[0] == 1'b0)
        else $error("full step left two-winding set");

    // Half step alternates one and two windings
    half_alt_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (half_fwd_s or half_rev_s) |=> pos[0] != $past(pos[0]))
        else $error("half step did not alternate");

    // Top index forward wraps to the start
    wrap_fwd_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        half_fwd_s ##0 (&pos) |=> pos == SPS_POS_INIT)
        else $error("forward wrap wrong");

    // Start index half-step reverse wraps to the top
    wrap_rev_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        half_rev_s ##0 (pos == SPS_POS_INIT) |=> (&pos))
        else $error("reverse wrap wrong");

endmodule

// ==== verif/sps_winding_model.sv ====
`timescale 1ns/1ns
// ==========================================
// Winding load model
module sps_winding_model
    import sps_pkg::*;
(
    input wire logic core_clk,
    input wire sps_phase_t phase_out,
    output logic [2:0] coils_on
);
    // Count energised switches; off drive carries no current
    always_ff @(posedge core_clk) begin
        coils_on <= 3'($countones(phase_out));
    end
endmodule

// ==== verif/stepper_phase_sequencer_tb.sv ====
`timescale 1ns/1ns
// ==========================================
// Self-checking bench
module stepper_phase_sequencer_tb
    import sps_pkg::*;
;
    logic core_clk = 1'b0; // 50 MHz core clock
    logic resetn = 1'b0; // Active low reset
    logic clk_en = 1'b1; // Clock enable
    logic step_clock = 1'b0; // Step pin
    logic mode_select = 1'b0; // Excitation mode pin
    logic direction_select = 1'b0; // Direction pin
    logic output_enable = 1'b1; // Drive enable pin
    sps_phase_t phase_out; // Winding drive
    logic [2:0] step_position; // Step index copy
    logic [2:0] coils_on; // Coil count from model
    logic [5:0] r; // Current row
    int fails = 0; // Mismatch count
    int checks = 0; // Comparison count
    int cyc = 0; // Timeout counter
    localparam int STEP_HALF = 500; // 10 us of core cycles per pin level
    localparam int CYC_LIMIT = 30000; // About 30 steps of 1000 cycles
    // Phase pattern per index
    logic [3:0] tbl [8] = '{4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
    // Rows: mode, dir, enable, expected index
    logic [5:0] rows [18] = '{6'h0a, 6'h0c, 6'h0e, 6'h08, 6'h0a, 6'h2b,
        6'h2c, 6'h2d, 6'h0e, 6'h1c, 6'h3b, 6'h3a, 6'h39, 6'h38, 6'h3f,
        6'h07, 6'h27, 6'h1e};

    sps_sequencer dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .step_clock(step_clock), .mode_select(mode_select),
        .direction_select(direction_select), .output_enable(output_enable),
        .phase_out(phase_out), .step_position(step_position));
    sps_winding_model load (.core_clk(core_clk), .phase_out(phase_out),
        .coils_on(coils_on));

    // Clock generator
    always #10 core_clk = ~core_clk;

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    // Compare and report
    task chk(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One step pulse: 10 us high, 10 us low, so 50 kHz at most
    task step(input logic [2:0] c);
        {mode_select, direction_select, output_enable} = c;
        @(negedge core_clk);
        step_clock = 1'b1;
        repeat (STEP_HALF) @(negedge core_clk);
        step_clock = 1'b0;
        repeat (STEP_HALF) @(negedge core_clk);
    endtask

    // Verdict
    task wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        chk(phase_out, 4'h0);
        resetn = 1'b1;
        for (int i = 0; i < 18; i++) begin
            r = rows[i];
            step(r[5:3]);
            chk({1'b0, step_position}, {1'b0, r[2:0]});
            chk(phase_out, r[3] ? tbl[r[2:0]] : 4'h0);
            chk({1'b0, coils_on}, r[3] ? 4'h2 - r[0] : 4'h0);
        end
        // Mode change with no step must not move
        mode_select = 1'b1;
        repeat (10) @(negedge core_clk);
        chk({1'b0, step_position}, 4'h6);
        // Clock enable low: a whole step pulse is ignored
        clk_en = 1'b0;
        step(3'b001);
        clk_en = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({1'b0, step_position}, 4'h6);
        // Reset in mid-run
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(phase_out, 4'h0);
        chk({1'b0, step_position}, 4'h0);
        // First step after release starts from the initial index
        resetn = 1'b1;
        step(3'b001);
        chk({1'b0, step_position}, 4'h2);
        chk(phase_out, 4'ha);
        wrap_up();
    end
endmodule
